//--- include/ubr_pkg.sv
package ubr_pkg;

   // register indices; byte address is four times the index
   localparam logic [7:0]  IDX_BREAK       = 8'h0a;
   localparam logic [7:0]  IDX_TURNAROUND  = 8'h0b;
   localparam logic [7:0]  IDX_PIN_FN      = 8'h0c;
   localparam logic [7:0]  IDX_BIT_PERIOD  = 8'h20;
   localparam logic [7:0]  IDX_STATUS      = 8'h21;
   localparam int          ADDR_LSB        = 2;
   localparam int          ADDR_W          = 10;

   // reset values
   localparam logic [15:0] BREAK_RST       = 16'h0000;
   localparam logic [3:0]  TURNAROUND_RST  = 4'h0;
   localparam logic [15:0] PIN_FN_RST      = 16'h0300;
   localparam logic [15:0] PIN_FN_MASK     = 16'h03ff;
   localparam logic [15:0] BIT_PERIOD_RST  = 16'h0364;

   // break register special values
   localparam logic [15:0] BREAK_FOREVER   = 16'hffff;
   localparam logic [15:0] BREAK_NONE      = 16'h0000;

   // pin function field positions
   localparam int          FN_RX_TOGGLE    = 9;
   localparam int          FN_TX_TOGGLE    = 8;
   localparam int          FN_CLK_OUT      = 7;
   localparam int          FN_P7_HI        = 6;
   localparam int          FN_P7_LO        = 5;
   localparam int          FN_PIN_SEL      = 4;
   localparam int          FN_POLARITY     = 3;
   localparam int          FN_MODEM_HI     = 2;
   localparam int          FN_MODEM_LO     = 0;

   // pin 7 enable codes
   localparam logic [1:0]  P7_GPIO         = 2'h0;
   localparam logic [1:0]  P7_EN_TX        = 2'h1;
   localparam logic [1:0]  P7_EN_MATCH     = 2'h2;

   // modem select codes
   localparam logic [2:0]  MODEM_GPIO      = 3'h0;
   localparam logic [2:0]  MODEM_RTS_CTS   = 3'h1;
   localparam logic [2:0]  MODEM_DTR_DSR   = 3'h2;
   localparam logic [2:0]  MODEM_EN_TX     = 3'h3;
   localparam logic [2:0]  MODEM_EN_MATCH  = 3'h4;

   // general pin numbers
   localparam int          PIN_DTR         = 2;
   localparam int          PIN_DSR         = 3;
   localparam int          PIN_CTS         = 4;
   localparam int          PIN_RTS         = 5;
   localparam int          PIN_CLK         = 6;
   localparam int          PIN_EN7         = 7;
   localparam int          PIN_TXT         = 8;
   localparam int          PIN_RXT         = 9;

   // status bit positions
   localparam int          ST_BREAK        = 0;
   localparam int          ST_DRIVING      = 1;
   localparam int          ST_TX_BUSY      = 2;

   // timing: one millisecond at the core clock
   localparam int          CLK_PERIOD_NS   = 10;
   localparam int          MS_TIME_NS      = 1000000;
   localparam int          MS_CYCLES       = MS_TIME_NS / CLK_PERIOD_NS;
   localparam int          TIMER_W         = 17;

   // pins owned by alternate functions, with their driven levels
   typedef struct packed {
      logic [9:0] alt;
      logic [9:0] val;
   } ubr_pins_t;

   // state of the period timer
   typedef struct packed {
      logic [TIMER_W-1:0] cnt;
      logic               tick;
   } ubr_timer_t;

   // state of the control block
   typedef struct packed {
      logic [15:0] brk_cnt;
      logic        brk_on;
      logic [3:0]  ta_dly;
      logic [15:0] pin_fn;
      logic [15:0] bit_period;
      logic [3:0]  ta_cnt;
      logic        ta_run;
      logic        tx_busy_d;
      logic [31:0] rdata;
      logic        err;
      ubr_pins_t   pins;
   } ubr_state_t;

endpackage

//--- hdl/ubr_timer.sv
// free period timer: one-cycle tick every period cycles while not held
module ubr_timer (
   input  wire logic                        pclk,
   input  wire logic                        presetn,
   input  wire logic                        restart,
   input  wire logic [ubr_pkg::TIMER_W-1:0] period,
   output logic                             tick
);

   ubr_pkg::ubr_timer_t s_q;
   ubr_pkg::ubr_timer_t s_d;

   // count up, wrap at period; restart holds at zero
   always_comb begin
      s_d      = s_q;
      s_d.tick = 1'b0;
      if (restart) begin
         s_d.cnt = '0;
      end else if (s_q.cnt + 1'b1 >= period) begin
         s_d.cnt  = '0;
         s_d.tick = 1'b1;
      end else begin
         s_d.cnt = s_q.cnt + 1'b1;
      end
   end

   // state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign tick = s_q.tick;

endmodule

//--- hdl/ubr_top.sv
// Overview of operation
// - all-ones break value: break held continuously
// - other nonzero: break N ms, counting down
// - zero value ends break
// - any break write aborts, new value applies
// - finish current character before break starts
// - break starts within one millisecond
// - break released within two character times
// - wait programmed bit times before line turnaround
// - bit 9 routes receive toggle to pin 9
// - bit 8 routes transmit toggle to pin 8
// - bit 7 routes clock output to pin 6
// - bits 6:5 set pin 7 enable kind
// - bit 4 enables the pin 7 enable output; pin 5 use is set by bits 2:0
// - bit 3 sets enable polarity
// - bits 2:0 select modem pin use
// - match enable follows multidrop address match
module ubr_top #(
   parameter int MS_CYCLES = ubr_pkg::MS_CYCLES
) (
   input  wire logic                      pclk,
   input  wire logic                      presetn,
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [ubr_pkg::ADDR_W-1:0] paddr,
   input  wire logic [31:0]               pwdata,
   output logic      [31:0]               prdata,
   output logic                           pready,
   output logic                           pslverr,
   input  wire logic                      tx_busy,
   input  wire logic                      addr_match,
   input  wire logic                      rx_toggle,
   input  wire logic                      tx_toggle,
   input  wire logic                      clk_out_src,
   input  wire logic                      rts_level,
   input  wire logic                      dtr_level,
   output logic                           tx_break,
   output logic                           line_driving,
   output ubr_pkg::ubr_pins_t             pins
);

   ubr_pkg::ubr_state_t s_q;
   ubr_pkg::ubr_state_t s_d;

   logic                        ms_tick;
   logic                        bit_tick;
   logic                        ms_restart;
   logic                        bit_restart;
   logic                        wr_en;
   logic                        brk_wr;
   logic [7:0]                  idx;
   logic                        en_tx;
   logic                        en_match;
   logic [1:0]                  p7_code;
   logic [2:0]                  modem_code;

   // register index from a byte address
   function automatic logic [7:0] word_index(input logic [ubr_pkg::ADDR_W-1:0] a);
      word_index = a[ubr_pkg::ADDR_W-1:ubr_pkg::ADDR_LSB];
   endfunction

   // apply the enable polarity to an enable level
   function automatic logic polar(input logic en, input logic active_high);
      polar = active_high ? en : ~en;
   endfunction

   // is the index one of the mapped registers
   function automatic logic mapped(input logic [7:0] i);
      mapped = (i == ubr_pkg::IDX_BREAK) || (i == ubr_pkg::IDX_TURNAROUND) ||
               (i == ubr_pkg::IDX_PIN_FN) || (i == ubr_pkg::IDX_BIT_PERIOD) ||
               (i == ubr_pkg::IDX_STATUS);
   endfunction

   // apb access decode; writes land in the access phase
   assign idx    = word_index(paddr);
   assign pready = psel & penable;
   assign wr_en  = psel & penable & pwrite & mapped(idx);
   assign brk_wr = wr_en && (idx == ubr_pkg::IDX_BREAK);

   // millisecond timer realigned on each break write or while idle
   assign ms_restart  = brk_wr | ~s_q.brk_on;
   // bit timer runs only during the turnaround wait
   assign bit_restart = ~s_q.ta_run;

   ubr_timer u_ms_timer (
      .pclk    (pclk),
      .presetn (presetn),
      .restart (ms_restart),
      .period  (ubr_pkg::TIMER_W'(MS_CYCLES)),
      .tick    (ms_tick)
   );

   ubr_timer u_bit_timer (
      .pclk    (pclk),
      .presetn (presetn),
      .restart (bit_restart),
      .period  ({1'b0, s_q.bit_period}),
      .tick    (bit_tick)
   );

   // enable sources and pin selector fields
   // the delayed busy bridges the cycle before the turnaround wait starts
   assign en_tx      = tx_busy | s_q.ta_run | s_q.brk_on |
                       (s_q.tx_busy_d && s_q.ta_dly != 4'h0);
   assign en_match   = addr_match;
   assign p7_code    = s_q.pin_fn[ubr_pkg::FN_P7_HI:ubr_pkg::FN_P7_LO];
   assign modem_code = s_q.pin_fn[ubr_pkg::FN_MODEM_HI:ubr_pkg::FN_MODEM_LO];

   // next-state logic
   always_comb begin
      s_d           = s_q;
      s_d.tx_busy_d = tx_busy;

      // break counter and output
      if (brk_wr) begin
         s_d.brk_cnt = pwdata[15:0];
         s_d.brk_on  = 1'b0;
         if (pwdata[15:0] != ubr_pkg::BREAK_NONE && !tx_busy) begin
            s_d.brk_on = 1'b1;
         end
      end else if (s_q.brk_cnt == ubr_pkg::BREAK_NONE) begin
         s_d.brk_on = 1'b0;
      end else if (!s_q.brk_on) begin
         if (!tx_busy) begin
            s_d.brk_on = 1'b1;
         end
      end else if (ms_tick && s_q.brk_cnt != ubr_pkg::BREAK_FOREVER) begin
         s_d.brk_cnt = s_q.brk_cnt - 16'h0001;
         if (s_q.brk_cnt == 16'h0001) begin
            s_d.brk_on = 1'b0;
         end
      end
      // all-ones never counts, so break holds until rewritten

      // turnaround wait after the last stop bit
      if (tx_busy || s_q.brk_on) begin
         s_d.ta_run = 1'b0;
         s_d.ta_cnt = '0;
      end else if (s_q.tx_busy_d && s_q.ta_dly != 4'h0) begin
         s_d.ta_run = 1'b1;
         s_d.ta_cnt = s_q.ta_dly;
      end else if (s_q.ta_run && bit_tick) begin
         s_d.ta_cnt = s_q.ta_cnt - 4'h1;
         if (s_q.ta_cnt == 4'h1) begin
            s_d.ta_run = 1'b0;
         end
      end

      // register writes
      if (wr_en) begin
         case (idx)
            ubr_pkg::IDX_TURNAROUND: s_d.ta_dly     = pwdata[3:0];
            ubr_pkg::IDX_PIN_FN:     s_d.pin_fn     = pwdata[15:0] & ubr_pkg::PIN_FN_MASK;
            ubr_pkg::IDX_BIT_PERIOD: s_d.bit_period = pwdata[15:0];
            default:                 s_d.err        = s_q.err;
         endcase
      end

      // read data and error captured in the setup phase
      if (psel && !penable) begin
         s_d.err   = ~mapped(idx);
         s_d.rdata = 32'h0000_0000;
         case (idx)
            ubr_pkg::IDX_BREAK:      s_d.rdata[15:0] = s_q.brk_cnt;
            ubr_pkg::IDX_TURNAROUND: s_d.rdata[3:0]  = s_q.ta_dly;
            ubr_pkg::IDX_PIN_FN:     s_d.rdata[15:0] = s_q.pin_fn;
            ubr_pkg::IDX_BIT_PERIOD: s_d.rdata[15:0] = s_q.bit_period;
            ubr_pkg::IDX_STATUS: begin
               s_d.rdata[ubr_pkg::ST_BREAK]   = s_q.brk_on;
               s_d.rdata[ubr_pkg::ST_DRIVING] = en_tx;
               s_d.rdata[ubr_pkg::ST_TX_BUSY] = tx_busy;
            end
            default: s_d.rdata = 32'h0000_0000;
         endcase
      end

      // alternate pin functions
      s_d.pins = '0;
      s_d.pins.alt[ubr_pkg::PIN_RXT] = s_q.pin_fn[ubr_pkg::FN_RX_TOGGLE];
      s_d.pins.val[ubr_pkg::PIN_RXT] = rx_toggle;
      s_d.pins.alt[ubr_pkg::PIN_TXT] = s_q.pin_fn[ubr_pkg::FN_TX_TOGGLE];
      s_d.pins.val[ubr_pkg::PIN_TXT] = tx_toggle;
      s_d.pins.alt[ubr_pkg::PIN_CLK] = s_q.pin_fn[ubr_pkg::FN_CLK_OUT];
      s_d.pins.val[ubr_pkg::PIN_CLK] = clk_out_src;

      // pin 7 only when bit 4 selects it
      if (s_q.pin_fn[ubr_pkg::FN_PIN_SEL]) begin
         case (p7_code)
            ubr_pkg::P7_EN_TX: begin
               s_d.pins.alt[ubr_pkg::PIN_EN7] = 1'b1;
               s_d.pins.val[ubr_pkg::PIN_EN7] =
                  polar(en_tx, s_q.pin_fn[ubr_pkg::FN_POLARITY]);
            end
            ubr_pkg::P7_EN_MATCH: begin
               s_d.pins.alt[ubr_pkg::PIN_EN7] = 1'b1;
               s_d.pins.val[ubr_pkg::PIN_EN7] =
                  polar(en_match, s_q.pin_fn[ubr_pkg::FN_POLARITY]);
            end
            default: s_d.pins.alt[ubr_pkg::PIN_EN7] = 1'b0;
         endcase
      end

      // modem pins; reserved codes fall back to plain i/o
      case (modem_code)
         ubr_pkg::MODEM_RTS_CTS: begin
            s_d.pins.alt[ubr_pkg::PIN_CTS] = 1'b1;
            s_d.pins.alt[ubr_pkg::PIN_RTS] = 1'b1;
            s_d.pins.val[ubr_pkg::PIN_RTS] = rts_level;
         end
         ubr_pkg::MODEM_DTR_DSR: begin
            s_d.pins.alt[ubr_pkg::PIN_DTR] = 1'b1;
            s_d.pins.alt[ubr_pkg::PIN_DSR] = 1'b1;
            s_d.pins.val[ubr_pkg::PIN_DTR] = dtr_level;
         end
         ubr_pkg::MODEM_EN_TX: begin
            s_d.pins.alt[ubr_pkg::PIN_RTS] = 1'b1;
            s_d.pins.val[ubr_pkg::PIN_RTS] =
               polar(en_tx, s_q.pin_fn[ubr_pkg::FN_POLARITY]);
         end
         ubr_pkg::MODEM_EN_MATCH: begin
            s_d.pins.alt[ubr_pkg::PIN_RTS] = 1'b1;
            s_d.pins.val[ubr_pkg::PIN_RTS] =
               polar(en_match, s_q.pin_fn[ubr_pkg::FN_POLARITY]);
         end
         default: s_d.pins.alt[ubr_pkg::PIN_RTS] = 1'b0;
      endcase
   end

   // state register with constant reset values
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q            <= '0;
         s_q.brk_cnt    <= ubr_pkg::BREAK_RST;
         s_q.ta_dly     <= ubr_pkg::TURNAROUND_RST;
         s_q.pin_fn     <= ubr_pkg::PIN_FN_RST;
         s_q.bit_period <= ubr_pkg::BIT_PERIOD_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // outputs from the state register; pslverr is also gated by pready
   assign prdata       = s_q.rdata;
   assign pslverr      = s_q.err & pready;
   assign tx_break     = s_q.brk_on;
   assign line_driving = s_q.brk_on | s_q.ta_run | s_q.tx_busy_d;
   assign pins         = s_q.pins;

endmodule

//--- bench/ubr_props.sv
module ubr_props #(
   parameter int MS_CYCLES = 20
) (
   input wire logic                       pclk,
   input wire logic                       presetn,
   input wire logic                       psel,
   input wire logic                       penable,
   input wire logic                       pwrite,
   input wire logic [ubr_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0]                pwdata,
   input wire logic                       tx_busy,
   input wire logic                       rx_toggle,
   input wire logic                       tx_toggle,
   input wire logic                       clk_out_src,
   input wire logic                       rts_level,
   input wire logic                       dtr_level,
   input wire logic                       tx_break,
   input wire logic                       line_driving,
   input wire ubr_pkg::ubr_pins_t         pins
);
   logic brk_wr;
   logic forever_q;

   // break register written in an access phase
   assign brk_wr = psel && penable && pwrite && paddr == 10'h028;

   // continuous break armed by an all-ones write while idle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) forever_q <= 1'b0;
      else if (brk_wr) forever_q <= pwdata[15:0] == 16'hffff && !tx_busy;
   end

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   // break control
   brk_forever_a: assert property (forever_q && $past(forever_q) |-> tx_break)
      else $error("continuous break dropped");
   brk_start_a: assert property (brk_wr && pwdata[15:0] != 16'h0000 && !tx_busy |-> ##2 tx_break)
      else $error("break did not start");
   brk_stop_a: assert property (brk_wr && pwdata[15:0] == 16'h0000 |-> ##2 !tx_break)
      else $error("break not stopped by zero");
   brk_after_char_a: assert property ($rose(tx_break) |-> !$past(tx_busy))
      else $error("break cut into a character");

   // alternate pin routing, one cycle behind its source
   rx_toggle_pin_a: assert property (pins.alt[9] && $past(pins.alt[9]) |-> pins.val[9] == $past(rx_toggle))
      else $error("receive toggle not on pin 9");
   tx_toggle_pin_a: assert property (pins.alt[8] && $past(pins.alt[8]) |-> pins.val[8] == $past(tx_toggle))
      else $error("transmit toggle not on pin 8");
   clk_out_pin_a: assert property (pins.alt[6] && $past(pins.alt[6]) |-> pins.val[6] == $past(clk_out_src))
      else $error("clock not on pin 6");
   dtr_pin_a: assert property (pins.alt[2] && $past(pins.alt[2]) |-> pins.val[2] == $past(dtr_level))
      else $error("dtr level not on pin 2");
   rts_pin_a: assert property (pins.alt[4] && $past(pins.alt[4]) |-> pins.val[5] == $past(rts_level))
      else $error("rts level not on pin 5");
   enable_span_a: assert property (tx_busy |=> line_driving)
      else $error("line released during a character");
endmodule

//--- bench/ubr_xcvr_model.sv
module ubr_xcvr_model #(
   parameter int CHAR_CYC = 40
) (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic start,
   input  wire logic match_in,
   output logic      tx_busy,
   output logic      addr_match,
   output logic      rx_toggle,
   output logic      tx_toggle,
   output logic      clk_out_src,
   output logic      rts_level,
   output logic      dtr_level
);
   timeunit 1ns;
   timeprecision 1ps;
   int         cnt;
   logic [2:0] div;

   // one frame per start request, start bit to last stop bit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 0;
         tx_toggle <= 1'b0;
      end else if (start && cnt == 0) begin
         cnt <= CHAR_CYC;
         tx_toggle <= ~tx_toggle;
      end else if (cnt > 0) begin
         cnt <= cnt - 1;
      end
   end
   assign tx_busy = cnt > 0;

   // receive activity, clock source and flow levels keep moving
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div <= 3'h0;
         rx_toggle <= 1'b0;
         clk_out_src <= 1'b0;
         addr_match <= 1'b0;
      end else begin
         div <= div + 3'h1;
         rx_toggle <= rx_toggle ^ (div == 3'h7);
         clk_out_src <= ~clk_out_src;
         addr_match <= match_in;
      end
   end
   assign rts_level = div[1];
   assign dtr_level = ~div[2];
endmodule

//--- bench/tb.sv
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int MS = 20;
   localparam int BP = 10;
   logic               pclk = 1'b0;
   logic               presetn = 1'b0;
   logic               psel = 1'b0;
   logic               penable = 1'b0;
   logic               pwrite = 1'b0;
   logic               start = 1'b0;
   logic               match_in = 1'b0;
   logic [9:0]         paddr = 10'h000;
   logic [31:0]        pwdata = 32'h0000_0000;
   logic [31:0]        prdata, rd;
   logic               pready, pslverr, err, tx_busy, addr_match, rx_toggle, tx_toggle;
   logic               clk_out_src, rts_level, dtr_level, tx_break, line_driving;
   ubr_pkg::ubr_pins_t pins;
   logic [15:0]        fn_tab [7] = '{16'h0000, 16'h0381, 16'h0002, 16'h0003, 16'h000c, 16'h0030, 16'h0058};
   int                 fails = 0;
   int                 comparisons = 0;
   int                 cyc = 0;
   int                 n;

   ubr_top #(.MS_CYCLES(MS)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .tx_busy, .addr_match, .rx_toggle, .tx_toggle, .clk_out_src, .rts_level,
      .dtr_level, .tx_break, .line_driving, .pins);
   ubr_xcvr_model i_far (.pclk, .presetn, .start, .match_in, .tx_busy, .addr_match, .rx_toggle,
      .tx_toggle, .clk_out_src, .rts_level, .dtr_level);

   // clock and hang guard
   always #5 pclk = ~pclk;
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         give_verdict();
      end
   end

   // one apb transfer, held until pready is seen
   task automatic apb(input logic wr, input logic [9:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      // a missing ready counts as a mismatch
      if (pready !== 1'b1) fails++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // comparisons
   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t %s: got %h want %h", $time, what, got, exp);
      end
   endtask
   task automatic chk_pin(input logic got, input logic exp, input string what);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t %s: got %b want %b", $time, what, got, exp);
      end
   endtask
   task automatic rd_chk(input logic [9:0] a, input logic [31:0] exp, input string what);
      apb(1'b0, a, 32'h0000_0000);
      chk_reg(rd, exp, what);
   endtask

   // stimulus helpers
   task automatic send_char;
      @(posedge pclk);
      start <= 1'b1;
      @(posedge pclk);
      start <= 1'b0;
   endtask
   task automatic wait_busy(input logic v);
      n = 0;
      while (tx_busy !== v && n < 100) begin
         @(negedge pclk);
         n++;
      end
      if (tx_busy !== v) fails++;
   endtask
   task automatic brk_wait;
      n = 2;
      repeat (2) @(negedge pclk);
      while (tx_break !== 1'b0 && n < 400) begin
         @(negedge pclk);
         n++;
      end
   endtask

   // pins owned by alternate functions for a pin function value
   function automatic logic [9:0] exp_alt(input logic [15:0] f);
      logic [9:0] a;
      a = {f[9], f[8], 8'h00};
      a[6] = f[7];
      a[7] = f[4] && (f[6:5] == 2'b01 || f[6:5] == 2'b10);
      case (f[2:0])
         3'h1: a[5:4] = 2'b11;
         3'h2: a[3:2] = 2'b11;
         3'h3, 3'h4: a[5] = 1'b1;
         default: ;
      endcase
      return a;
   endfunction

   task automatic done(input string what);
      $display("test %s done", what);
   endtask
   task automatic give_verdict;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // main sequence
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd_chk(10'h028, 32'h0000_0000, "break reset");
      rd_chk(10'h02c, 32'h0000_0000, "delay reset");
      rd_chk(10'h030, 32'h0000_0300, "pin fn reset");
      rd_chk(10'h034, 32'h0000_0000, "unmapped read");
      chk_pin(err, 1'b1, "unmapped error");
      chk_reg({22'h0, pins.alt}, 32'h0000_0300, "owners after reset");
      apb(1'b1, 10'h02c, 32'h0000_fff3);
      rd_chk(10'h02c, 32'h0000_0003, "delay width");
      done("reset");
      foreach (fn_tab[i]) begin
         apb(1'b1, 10'h030, {16'h0000, fn_tab[i]});
         rd_chk(10'h030, {16'h0000, fn_tab[i]}, "pin fn readback");
         @(negedge pclk);
         chk_reg({22'h0, pins.alt}, {22'h0, exp_alt(fn_tab[i])}, "pin owners");
      end
      for (int v = 1; v >= 0; v--) begin
         @(posedge pclk);
         match_in <= v[0];
         repeat (3) @(negedge pclk);
         chk_pin(pins.val[7], v[0], "match enable");
      end
      done("pin select");
      apb(1'b1, 10'h080, BP);
      for (int i = 0; i < 2; i++) begin
         apb(1'b1, 10'h02c, i ? 32'h0000_0000 : 32'h0000_0003);
         apb(1'b1, 10'h030, i ? 32'h0000_0003 : 32'h0000_000b);
         // pins follow the new function one edge after the write
         repeat (2) @(negedge pclk);
         chk_pin(pins.val[5], i[0], "idle enable");
         send_char();
         wait_busy(1'b1);
         repeat (3) @(negedge pclk);
         chk_pin(pins.val[5], !i[0], "enable while sending");
         wait_busy(1'b0);
         n = 0;
         while (pins.val[5] !== i[0] && n < 100) begin
            @(negedge pclk);
            n++;
         end
         chk_pin(n >= (i ? 0 : 3*BP) && n <= (i ? 3 : 3*BP+4), 1'b1, "turnaround");
      end
      done("turnaround");
      apb(1'b1, 10'h028, 32'h0000_0003);
      brk_wait();
      chk_pin(n >= 3*MS && n <= 3*MS+5, 1'b1, "timed break");
      rd_chk(10'h028, 32'h0000_0000, "count at end");
      apb(1'b1, 10'h028, 32'h0000_0003);
      repeat (MS + 5) @(posedge pclk);
      rd_chk(10'h028, 32'h0000_0002, "count after one ms");
      apb(1'b1, 10'h028, 32'h0000_0001);
      brk_wait();
      chk_pin(n >= MS && n <= MS+5, 1'b1, "rewritten break");
      apb(1'b1, 10'h028, 32'h0000_ffff);
      repeat (300) @(posedge pclk);
      rd_chk(10'h028, 32'h0000_ffff, "continuous count");
      rd_chk(10'h084, 32'h0000_0003, "status in break");
      apb(1'b1, 10'h028, 32'h0000_0000);
      repeat (2) @(negedge pclk);
      chk_pin(tx_break, 1'b0, "zero stops break");
      send_char();
      repeat (5) @(posedge pclk);
      apb(1'b1, 10'h028, 32'h0000_0002);
      repeat (2) @(negedge pclk);
      chk_pin(tx_break, 1'b0, "break waits");
      wait_busy(1'b0);
      repeat (3) @(negedge pclk);
      chk_pin(tx_break, 1'b1, "break after char");
      apb(1'b1, 10'h028, 32'h0000_0000);
      done("break");
      give_verdict();
   end
endmodule

bind ubr_top ubr_props #(.MS_CYCLES(MS_CYCLES)) i_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .pwdata, .tx_busy, .rx_toggle, .tx_toggle, .clk_out_src, .rts_level, .dtr_level, .tx_break,
   .line_driving, .pins);
